// file: gec_top.sv
// Purpose: Gesture engine entry and exit control with its three registers.
// Assumes: Register port and sensor inputs come from logic on clk_in.
// Notes:   Register reads return data one cycle after the read strobe.
module gec_top (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // Register port.
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  output logic      [7:0]          reg_rdata_out,
  // Proximity result.
  input  wire logic                prox_valid_in,
  input  wire logic [7:0]          proximity_result_in,
  // Directional datasets.
  input  wire logic                dir_valid_in,
  input  wire gec_pkg::gec_dir_type dir_data_in,
  // FIFO level and gesture mode control.
  input  wire logic [5:0]          fifo_level_in,
  input  wire logic                gesture_int_enable_in,
  input  wire logic                gesture_mode_clear_in,
  // Results.
  output logic                     gesture_active_flag_out,
  output logic                     gesture_int_out
);

  logic [7:0]              entry_thr_r;
  logic [7:0]              exit_thr_r;
  logic [7:0]              config_one_r;
  logic [7:0]              rdata_r;
  gec_pkg::gec_state_type  state_r;
  logic                    int_r;
  logic                    entry_hit;
  logic                    exit_pulse;
  logic [5:0]              fifo_need;
  logic                    active;

  assign active = (state_r == gec_pkg::GEC_ACTIVE);

  // Register writes; the stored value is kept exactly as written.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      entry_thr_r  <= gec_pkg::ENTRY_THR_RESET;
      exit_thr_r   <= gec_pkg::EXIT_THR_RESET;
      config_one_r <= gec_pkg::CONFIG_ONE_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == gec_pkg::ENTRY_THR_ADDR) begin
        entry_thr_r <= reg_wdata_in;
      end else if (reg_addr_in == gec_pkg::EXIT_THR_ADDR) begin
        exit_thr_r <= reg_wdata_in;
      end else if (reg_addr_in == gec_pkg::CONFIG_ONE_ADDR) begin
        config_one_r <= reg_wdata_in;
      end
    end
  end

  // Register reads; unmapped addresses return zero.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == gec_pkg::ENTRY_THR_ADDR) begin
        rdata_r <= entry_thr_r;
      end else if (reg_addr_in == gec_pkg::EXIT_THR_ADDR) begin
        rdata_r <= exit_thr_r;
      end else if (reg_addr_in == gec_pkg::CONFIG_ONE_ADDR) begin
        rdata_r <= config_one_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // A single qualifying proximity sample starts a gesture.
  assign entry_hit = prox_valid_in &&
                     (proximity_result_in >= entry_thr_r);

  gec_exit_detect u_exit (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .active_in    (active),
    .dir_valid_in (dir_valid_in),
    .dir_data_in  (dir_data_in),
    .exit_thr_in  (exit_thr_r),
    .exit_mask_in (config_one_r[gec_pkg::MASK_MSB:gec_pkg::MASK_LSB]),
    .exit_pers_in (config_one_r[gec_pkg::PERS_MSB:gec_pkg::PERS_LSB]),
    .exit_out     (exit_pulse)
  );

  // Gesture state; a host clear ends an active gesture, but in idle it is ignored and an entry hit still starts one.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= gec_pkg::GEC_IDLE;
    end else begin
      case (state_r)
        gec_pkg::GEC_IDLE: begin
          if (entry_hit) begin
            state_r <= gec_pkg::GEC_ACTIVE;
          end
        end
        gec_pkg::GEC_ACTIVE: begin
          if (gesture_mode_clear_in || exit_pulse) begin
            state_r <= gec_pkg::GEC_IDLE;
          end
        end
        default: begin
          state_r <= gec_pkg::GEC_IDLE;
        end
      endcase
    end
  end

  // FIFO level interrupt.
  assign fifo_need = gec_pkg::gec_fifo_need(
    config_one_r[gec_pkg::FIFO_SEL_MSB:gec_pkg::FIFO_SEL_LSB]);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      int_r <= 1'b0;
    end else begin
      int_r <= gesture_int_enable_in && (fifo_level_in >= fifo_need);
    end
  end

  assign reg_rdata_out           = rdata_r;
  assign gesture_active_flag_out = active;
  assign gesture_int_out         = int_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_entry_seen;
    !active && prox_valid_in && proximity_result_in >= entry_thr_r;
  endsequence

  sequence s_now_active;
    active;
  endsequence

  chk_entry_on_hit: assert property (
    s_entry_seen |=> s_now_active)
    else $error("Gesture state not entered on threshold hit.");

  chk_no_entry_below: assert property (
    !active && !(prox_valid_in && proximity_result_in >= entry_thr_r)
    |=> !active)
    else $error("Gesture state entered without a qualifying sample.");

  chk_zero_exit_holds: assert property (
    active && !exit_pulse && exit_thr_r == 8'h00 &&
    !gesture_mode_clear_in &&
    !(reg_wr_in && reg_addr_in == gec_pkg::EXIT_THR_ADDR)
    |=> active ##1 (active || $past(gesture_mode_clear_in)))
    else $error("Left gesture state with a zero exit threshold.");

  chk_exit_leaves: assert property (
    active && exit_pulse |=> !active)
    else $error("Exit pulse did not end the gesture state.");

  chk_stay_without_exit: assert property (
    active && !exit_pulse && !gesture_mode_clear_in |=> active)
    else $error("Gesture state left without exit or clear.");

  chk_fifo_sixteen: assert property (
    gesture_int_enable_in &&
    config_one_r[gec_pkg::FIFO_SEL_MSB:gec_pkg::FIFO_SEL_LSB] == 2'h3 &&
    fifo_level_in == 6'h0f |=> !gesture_int_out)
    else $error("Interrupt raised below sixteen datasets.");

  chk_fifo_int_level: assert property (
    gesture_int_enable_in && fifo_level_in >= fifo_need
    |=> gesture_int_out)
    else $error("Enabled interrupt missing at FIFO threshold.");

  chk_fifo_int_masked: assert property (
    !gesture_int_enable_in |=> !gesture_int_out)
    else $error("Interrupt raised while disabled.");

  sequence s_entry_write;
    reg_wr_in && reg_addr_in == gec_pkg::ENTRY_THR_ADDR;
  endsequence

  sequence s_exit_write;
    reg_wr_in && reg_addr_in == gec_pkg::EXIT_THR_ADDR;
  endsequence

  sequence s_config_write;
    reg_wr_in && reg_addr_in == gec_pkg::CONFIG_ONE_ADDR;
  endsequence

  chk_entry_thr_kept: assert property (
    s_entry_write |=> entry_thr_r == $past(reg_wdata_in))
    else $error("Entry threshold not stored as written.");

  chk_exit_thr_kept: assert property (
    s_exit_write |=> exit_thr_r == $past(reg_wdata_in))
    else $error("Exit threshold not stored as written.");

  chk_config_kept: assert property (
    s_config_write |=> config_one_r == $past(reg_wdata_in))
    else $error("Gesture configuration not stored as written.");

  chk_clear_leaves: assert property (
    active && gesture_mode_clear_in |=> !active)
    else $error("Host clear did not end the gesture state.");

  chk_fifo_int_below: assert property (
    !(fifo_level_in >= fifo_need) |=> !gesture_int_out)
    else $error("Interrupt raised below the FIFO threshold.");

endmodule

// file: gec_pkg.sv
// Purpose: Shared constants and types for the gesture entry and exit control.
// Assumes: Single 25 MHz clock domain; synchronous active high reset.
// Notes:   Register offsets are byte addresses on the register port.
package gec_pkg;

  localparam logic [7:0] ENTRY_THR_ADDR = 8'ha0;
  localparam logic [7:0] EXIT_THR_ADDR  = 8'ha1;
  localparam logic [7:0] CONFIG_ONE_ADDR = 8'ha2;

  localparam logic [7:0] ENTRY_THR_RESET = 8'h00;
  localparam logic [7:0] EXIT_THR_RESET  = 8'h00;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;

  localparam int FIFO_SEL_MSB = 7;
  localparam int FIFO_SEL_LSB = 6;
  localparam int MASK_MSB     = 5;
  localparam int MASK_LSB     = 2;
  localparam int PERS_MSB     = 1;
  localparam int PERS_LSB     = 0;

  localparam logic [5:0] FIFO_NEED_0 = 6'h01;
  localparam logic [5:0] FIFO_NEED_1 = 6'h04;
  localparam logic [5:0] FIFO_NEED_2 = 6'h08;
  localparam logic [5:0] FIFO_NEED_3 = 6'h10;

  localparam logic [2:0] PERS_NEED_0 = 3'h1;
  localparam logic [2:0] PERS_NEED_1 = 3'h2;
  localparam logic [2:0] PERS_NEED_2 = 3'h4;
  localparam logic [2:0] PERS_NEED_3 = 3'h7;

  typedef enum logic [0:0] {
    GEC_IDLE   = 1'b0,
    GEC_ACTIVE = 1'b1
  } gec_state_type;

  // One dataset from the four directional diodes.
  typedef struct packed {
    logic [7:0] up;
    logic [7:0] down;
    logic [7:0] left;
    logic [7:0] right;
  } gec_dir_type;

  function automatic logic [5:0] gec_fifo_need(input logic [1:0] sel);
    logic [5:0] need;
    case (sel)
      2'h0:    need = FIFO_NEED_0;
      2'h1:    need = FIFO_NEED_1;
      2'h2:    need = FIFO_NEED_2;
      default: need = FIFO_NEED_3;
    endcase
    return need;
  endfunction

  function automatic logic [2:0] gec_pers_need(input logic [1:0] sel);
    logic [2:0] need;
    case (sel)
      2'h0:    need = PERS_NEED_0;
      2'h1:    need = PERS_NEED_1;
      2'h2:    need = PERS_NEED_2;
      default: need = PERS_NEED_3;
    endcase
    return need;
  endfunction

endpackage

// file: gec_exit_detect.sv
// Purpose: Gesture end detection with mask and exit persistence counting.
// Assumes: Datasets arrive as one-cycle valid pulses on the same clock.
// Notes:   The exit pulse comes one cycle after the qualifying dataset.
module gec_exit_detect (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // Dataset and settings.
  input  wire logic                active_in,
  input  wire logic                dir_valid_in,
  input  wire gec_pkg::gec_dir_type dir_data_in,
  input  wire logic [7:0]          exit_thr_in,
  input  wire logic [3:0]          exit_mask_in,
  input  wire logic [1:0]          exit_pers_in,
  // Result.
  output logic                     exit_out
);

  logic [31:0] dir_vec;
  logic [3:0]  below;
  logic        end_det;
  logic [2:0]  need;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        exit_r;

  assign dir_vec = dir_data_in;

  // Each unmasked diode must sit below the threshold; bit 0 is right.
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_dir
      assign below[i] = exit_mask_in[i] |
                        (dir_vec[8*i +: 8] < exit_thr_in);
    end
  endgenerate

  // A zero threshold never yields a gesture end.
  assign end_det = (exit_thr_in != 8'h00) & (&below);
  assign need    = gec_pkg::gec_pers_need(exit_pers_in);
  assign cnt_nxt = 3'(cnt_r + 3'h1);

  // Consecutive gesture end counter.
  always_ff @(posedge clk_in) begin
    if (reset_in || !active_in) begin
      cnt_r  <= 3'h0;
      exit_r <= 1'b0;
    end else begin
      exit_r <= 1'b0;
      if (dir_valid_in) begin
        if (!end_det) begin
          cnt_r <= 3'h0;
        end else if (cnt_nxt == need) begin
          cnt_r  <= 3'h0;
          exit_r <= 1'b1;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  end

  assign exit_out = exit_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_exit_count_reached: assert property (
    exit_r |-> $past(cnt_r) == 3'(need - 3'h1))
    else $error("Exit raised before the persistence count.");

  chk_miss_clears_count: assert property (
    active_in && dir_valid_in && !end_det |=> cnt_r == 3'h0)
    else $error("Counter kept value after a non-end dataset.");

  chk_mask_open_right: assert property (
    active_in && dir_valid_in && exit_mask_in == 4'h0 &&
    dir_data_in.right >= exit_thr_in |=> !exit_r)
    else $error("Unmasked right diode above threshold gave exit.");

  chk_mask_drops_up: assert property (
    active_in && dir_valid_in && exit_mask_in == 4'h8 &&
    exit_thr_in != 8'h00 && dir_data_in.right < exit_thr_in &&
    dir_data_in.left < exit_thr_in && dir_data_in.down < exit_thr_in
    |-> end_det)
    else $error("Masked up diode still blocked gesture end.");

endmodule

// file: gec_host_model.sv
// Purpose: Host processor model driving the register port and mode control.
// Assumes: Tasks are called from the bench; changes follow a rising edge.
// Notes:   Released address and data lines show the inverse of the last value.
module gec_host_model (
  // Clock.
  input  wire logic       clk_in,
  // Register port.
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  // Gesture control.
  output logic            int_enable_out,
  output logic            mode_clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    int_enable_out = 1'b0;
    mode_clear_out = 1'b0;
  end
  // Writes one register; the entry threshold always goes out with bit 4 low.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= (a == gec_pkg::ENTRY_THR_ADDR) ? (d & 8'hef) : d;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
  endtask
  task automatic ctl(input logic en, input logic clr);
    @(posedge clk_in);
    int_enable_out <= en;
    mode_clear_out <= clr;
  endtask
endmodule

// file: gec_top_tb_top.sv
// Purpose: Self-checking bench for the gesture entry and exit control.
// Assumes: Results are noted in a queue and checked by a watcher process.
// Notes:   Each check looks two edges after the stimulus that causes it.
module gec_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] value;
  } gec_note_type;
  logic                 clk_in;
  logic                 reset_in;
  logic                 wr, rd, en, clr, pv, dv, look, flag, gint;
  logic [7:0]           addr, wdata, rdata, pres, ent, seen;
  logic [5:0]           lvl;
  gec_pkg::gec_dir_type dir, d;
  gec_note_type         notes[$];
  gec_note_type         note;
  int                   fails, comparisons, cycles;
  int                   pn[4] = '{1, 2, 4, 7};
  int                   fn[4] = '{1, 4, 8, 16};
  logic [31:0]          seed;
  gec_host_model host_u (.clk_in(clk_in), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .int_enable_out(en),
    .mode_clear_out(clr));
  gec_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .prox_valid_in(pv), .proximity_result_in(pres),
    .dir_valid_in(dv), .dir_data_in(dir), .fifo_level_in(lvl),
    .gesture_int_enable_in(en), .gesture_mode_clear_in(clr),
    .gesture_active_flag_out(flag), .gesture_int_out(gint));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction
  task automatic compare(input logic [7:0] s, input logic [7:0] w);
    comparisons++;
    if (s !== w) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, w);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Notes an expected result: kind 0 read data, 1 active flag, 2 interrupt.
  task automatic chk(input logic [1:0] k, input logic [7:0] v);
    notes.push_back(gec_note_type'{k, v});
    repeat (2) @(posedge clk_in);
    look <= 1'b1;
    @(posedge clk_in);
    look <= 1'b0;
  endtask
  task automatic prox(input logic [7:0] v);
    @(posedge clk_in);
    pv <= 1'b1;
    pres <= v;
    @(posedge clk_in);
    pv <= 1'b0;
    pres <= ~v;
  endtask
  task automatic dset(input gec_pkg::gec_dir_type v);
    @(posedge clk_in);
    dv <= 1'b1;
    dir <= v;
    @(posedge clk_in);
    dv <= 1'b0;
    dir <= ~v;
  endtask
  always @(negedge clk_in) begin
    if (look && notes.size() > 0) begin
      note = notes.pop_front();
      seen = (note.kind == 2'h0) ? rdata : {7'h0, note.kind[1] ? gint : flag};
      compare(seen, note.value);
    end
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    seed = 32'h191cc477;
    reset_in = 1'b1;
    {pv, dv, look, pres, dir, lvl} = '0;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (pn[i]) begin
      host_u.rd(8'ha0 + 8'(i));
      chk(2'h0, 8'h00);
    end
    host_u.wr(8'ha3, 8'hff);
    host_u.rd(8'ha3);
    chk(2'h0, 8'h00);
    $display("test reset_and_map done");
    ent = 8'h40 | (rnd() & 8'h2f);
    host_u.wr(gec_pkg::ENTRY_THR_ADDR, ent);
    host_u.rd(gec_pkg::ENTRY_THR_ADDR);
    chk(2'h0, ent);
    prox(ent - 8'h01);
    chk(2'h1, 8'h00);
    prox(ent);
    chk(2'h1, 8'h01);
    dset(32'h0);
    chk(2'h1, 8'h01);
    host_u.ctl(1'b0, 1'b1);
    host_u.ctl(1'b0, 1'b0);
    chk(2'h1, 8'h00);
    $display("test entry done");
    host_u.wr(gec_pkg::EXIT_THR_ADDR, 8'h80);
    for (int p = 0; p < 4; p++) begin
      host_u.wr(gec_pkg::CONFIG_ONE_ADDR, 8'(p));
      prox(ent);
      repeat (pn[p] - 1) dset(rnd() & 32'h7f7f7f7f);
      d = (rnd() & 32'h7f7f7f7f) | (32'h80 << (8 * (rnd() & 3)));
      dset(d);
      repeat (pn[p] - 1) dset(rnd() & 32'h7f7f7f7f);
      chk(2'h1, 8'h01);
      dset(rnd() & 32'h7f7f7f7f);
      chk(2'h1, 8'h00);
    end
    $display("test persistence done");
    host_u.wr(gec_pkg::EXIT_THR_ADDR, 8'h40);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(gec_pkg::CONFIG_ONE_ADDR, 8'h00);
      prox(ent);
      d = (rnd() & 32'h3f3f3f3f) | (32'h40 << (8 * i));
      dset(d);
      chk(2'h1, 8'h01);
      host_u.wr(gec_pkg::CONFIG_ONE_ADDR, 8'(1 << (i + 2)));
      dset(d);
      chk(2'h1, 8'h00);
    end
    $display("test exit_mask done");
    for (int s = 0; s < 4; s++) begin
      host_u.wr(gec_pkg::CONFIG_ONE_ADDR, 8'(s << 6));
      host_u.ctl(1'b1, 1'b0);
      @(posedge clk_in) lvl <= 6'(fn[s] - 1);
      chk(2'h2, 8'h00);
      @(posedge clk_in) lvl <= 6'(fn[s]);
      chk(2'h2, 8'h01);
      host_u.ctl(1'b0, 1'b0);
      chk(2'h2, 8'h00);
    end
    $display("test fifo_interrupt done");
    wrap_up();
  end
endmodule
